// File: rtl/fsc_bus_cycle.sv
// pin engine: one asynchronous write or read cycle on the flash strobes
// assumes dqIn is synchronous to sys_clk; one request at a time
`default_nettype none
`include "fsc_map.svh"
module fsc_bus_cycle
  import fsc_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  fsc_cyc_if.eng     cyc,
  output var  logic  chipEnN,
  output var  logic  outEnN,
  output var  logic  wrEnN,
  output var  fsc_addr_t flashAddr,
  output var  fsc_data_t dqOut,
  output var  logic  dqOeN,
  input  wire fsc_data_t dqIn
);

  typedef struct packed {
    fsc_bstate_t st;
    logic        isWrite;
    logic [3:0]  cnt;
    logic        ceN;
    logic        oeN;
    logic        weN;
    fsc_addr_t   addr;
    fsc_data_t   dout;
    logic        drvN;
    logic        done;
    fsc_data_t   rdata;
  } fsc_bus_st_t;

  fsc_bus_st_t r;
  fsc_bus_st_t next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.st)
      FSC_B_IDLE: begin
        if (cyc.req) begin
          next_r.st      = FSC_B_SETUP;
          next_r.isWrite = cyc.isWrite;
          next_r.addr    = cyc.addr;
          next_r.dout    = cyc.wdata;
          next_r.ceN     = 1'b0;
          next_r.drvN    = ~cyc.isWrite;
        end
      end
      FSC_B_SETUP: begin
        next_r.st = FSC_B_PULSE;
        if (r.isWrite) begin
          next_r.weN = 1'b0;
          next_r.cnt = 4'(`FSC_WE_CYC - 1);
        end else begin
          next_r.oeN = 1'b0;
          next_r.cnt = 4'(`FSC_RD_CYC - 1);
        end
      end
      FSC_B_PULSE: begin
        if (r.cnt == 4'h0) begin
          // rising strobe edge latches a command or ends the read
          next_r.st  = FSC_B_HOLD;
          next_r.weN = 1'b1;
          next_r.oeN = 1'b1;
          next_r.ceN = 1'b1;
          next_r.cnt = 4'(`FSC_HOLD_CYC - 1);
          if (!r.isWrite) begin
            next_r.rdata = dqIn;
          end
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      FSC_B_HOLD: begin
        // data bus released only after the hold time past the edge
        if (r.cnt == 4'h0) begin
          next_r.st   = FSC_B_IDLE;
          next_r.drvN = 1'b1;
          next_r.done = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      default: next_r.st = FSC_B_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: FSC_B_IDLE, isWrite: 1'b0, cnt: 4'h0, ceN: 1'b1, oeN: 1'b1,
             weN: 1'b1, addr: '0, dout: '0, drvN: 1'b1, done: 1'b0, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  assign chipEnN   = r.ceN;
  assign outEnN    = r.oeN;
  assign wrEnN     = r.weN;
  assign flashAddr = r.addr;
  assign dqOut     = r.dout;
  assign dqOeN     = r.drvN;
  assign cyc.done  = r.done;
  assign cyc.rdata = r.rdata;

  strobe_excl_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(!r.oeN && !r.weN) && (r.ceN -> (r.oeN && r.weN)))
    else $error("output and write strobes overlap or run without chip enable");
  no_contend_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !r.drvN |-> r.oeN)
    else $error("data bus driven during a read strobe");
  we_width_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(r.weN) |-> !r.weN [*4] ##1 r.weN)
    else $error("write strobe width is not four cycles");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    r.done |=> !r.done && r.ceN)
    else $error("cycle done is not a single pulse");

endmodule // fsc_bus_cycle
`default_nettype wire

// File: rtl/fsc_cyc_if.sv
// one bus cycle request between sequencer and pin engine
// assumes a single sys_clk domain; req and done are one-cycle pulses
`default_nettype none
interface fsc_cyc_if;
  import fsc_pkg::*;
  logic      req;
  logic      isWrite;
  fsc_addr_t addr;
  fsc_data_t wdata;
  logic      done;
  fsc_data_t rdata;
  modport ctrl (output req, output isWrite, output addr, output wdata,
                input done, input rdata);
  modport eng  (input req, input isWrite, input addr, input wdata,
                output done, output rdata);
endinterface : fsc_cyc_if
`default_nettype wire

// File: rtl/fsc_map.svh
// constants of the flash status/reset controller: commands, addresses, timing
// assumes a 100 MHz sys_clk and a x16 flash with word addressing
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

`define FSC_ADDR_W        26
`define FSC_DATA_W        16
`define FSC_CLK_NS        10
// command words and unlock addresses, plain defaults
`define FSC_UNLOCK_A1     26'h0000555
`define FSC_UNLOCK_A2     26'h00002AA
`define FSC_UNLOCK_D1     16'h00AA
`define FSC_UNLOCK_D2     16'h0055
`define FSC_CMD_STATUS    16'h0070
`define FSC_CMD_CLEAR     16'h0071
`define FSC_CMD_SOFTRST   16'h00F0
`define FSC_CMD_ERS_SUSP  16'h00B0
`define FSC_CMD_PRG_SUSP  16'h0051
`define FSC_CMD_ERS_RES   16'h0030
`define FSC_CMD_PRG_RES   16'h0050
`define FSC_CMD_ECC_ENTRY 16'h0075
// status word layout
`define FSC_BIT_READY     7
`define FSC_BIT_ERS_SUSP  6
`define FSC_BIT_ERS_FAIL  5
`define FSC_BIT_PRG_FAIL  4
`define FSC_BIT_ABORT     3
`define FSC_BIT_PRG_SUSP  2
`define FSC_BIT_LOCKED    1
`define FSC_MASK_DEFINED  16'h00FE
`define FSC_MASK_READY    16'h0080
// timing in ns and derived cycles (least times round up)
`define FSC_T_WE_NS       40
`define FSC_T_RD_NS       100
`define FSC_T_HOLD_NS     20
`define FSC_T_HWRST_NS    200
`define FSC_T_RECOVER_NS  35000
`define FSC_WE_CYC   ((`FSC_T_WE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_RD_CYC   ((`FSC_T_RD_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_HOLD_CYC ((`FSC_T_HOLD_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_HWRST_CYC ((`FSC_T_HWRST_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_RECOVER_CYC ((`FSC_T_RECOVER_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_POLL_LIMIT    1023

`endif

// File: rtl/fsc_pkg.sv
// types shared by the flash status/reset controller modules
// assumes fsc_map.svh supplies the widths
`default_nettype none
`include "fsc_map.svh"
package fsc_pkg;

  typedef enum logic [3:0] {
    FSC_OP_STATUS    = 4'h0,
    FSC_OP_CLEAR     = 4'h1,
    FSC_OP_SOFTRST   = 4'h2,
    FSC_OP_ERS_SUSP  = 4'h3,
    FSC_OP_PRG_SUSP  = 4'h4,
    FSC_OP_ERS_RES   = 4'h5,
    FSC_OP_PRG_RES   = 4'h6,
    FSC_OP_ECC_ENTRY = 4'h7,
    FSC_OP_HWRST     = 4'h8
  } fsc_op_t;

  typedef enum logic [4:0] {
    FSC_S_IDLE  = 5'h01,
    FSC_S_WRITE = 5'h02,
    FSC_S_READ  = 5'h04,
    FSC_S_HWRST = 5'h08,
    FSC_S_DONE  = 5'h10
  } fsc_state_t;

  typedef enum logic [3:0] {
    FSC_B_IDLE  = 4'h1,
    FSC_B_SETUP = 4'h2,
    FSC_B_PULSE = 4'h4,
    FSC_B_HOLD  = 4'h8
  } fsc_bstate_t;

  typedef logic [`FSC_ADDR_W-1:0] fsc_addr_t;
  typedef logic [`FSC_DATA_W-1:0] fsc_data_t;

endpackage : fsc_pkg
`default_nettype wire

// File: rtl/fsc_status_ctrl.sv
// host sequencer for flash status read, clear, soft reset, suspend/resume
// and ecc overlay entry; also pulses the flash hardware reset pin
// assumes the flash pins are wired directly and dqIn is synchronous
`default_nettype none
`include "fsc_map.svh"
// Behaviour
// - host falls back to hardware reset pulse when polling never recovers.
// - reserved bits 15:8 and 0 are masked by the host.
// - bit 7 one means idle; bits 6:1 ignored while busy.
// - after a suspend command the host polls status until ready.
module fsc_status_ctrl
  import fsc_pkg::*;
#(
  parameter int unsigned RECOVER_CYC = `FSC_RECOVER_CYC
)
(
  input  wire logic      sys_clk,
  input  wire logic      rstn,
  input  wire logic      cmdValid,
  input  wire logic [3:0] cmdOp,
  input  wire fsc_addr_t cmdAddr,
  output var  logic      cmdReady,
  output var  logic      rspValid,
  output var  fsc_data_t rspStatus,
  output var  logic      rspRefused,
  output var  logic      rspTimeout,
  output var  logic      chipEnN,
  output var  logic      outEnN,
  output var  logic      wrEnN,
  output var  logic      hwResetN,
  output var  fsc_addr_t flashAddr,
  output var  fsc_data_t dqOut,
  output var  logic      dqOeN,
  input  wire fsc_data_t dqIn
);

  typedef struct packed {
    fsc_state_t st;
    fsc_op_t    op;
    fsc_addr_t  addr;
    logic [1:0] step;
    logic       polling;
    logic [9:0] polls;
    logic       req;
    logic       isWrite;
    fsc_addr_t  cAddr;
    fsc_data_t  cData;
    logic       issued;
    logic [15:0] cnt;
    logic       devReady;
    logic       ready;
    logic       rsp;
    fsc_data_t  status;
    logic       refused;
    logic       timeout;
    logic       hwN;
  } fsc_ctrl_st_t;

  fsc_ctrl_st_t r;
  fsc_ctrl_st_t next_r;
  fsc_cyc_if    cyc ();

  fsc_bus_cycle u_bus (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .cyc       (cyc),
    .chipEnN   (chipEnN),
    .outEnN    (outEnN),
    .wrEnN     (wrEnN),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqOeN     (dqOeN),
    .dqIn      (dqIn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write sequence of each op: {last, address, data} for a given step

  function automatic logic [`FSC_ADDR_W+`FSC_DATA_W:0] fsc_write_step(
    input fsc_op_t op, input logic polling, input logic [1:0] step,
    input fsc_addr_t addr);
    fsc_data_t cmd;
    cmd = `FSC_CMD_STATUS;
    case (op)
      FSC_OP_CLEAR:     cmd = `FSC_CMD_CLEAR;
      FSC_OP_SOFTRST:   cmd = `FSC_CMD_SOFTRST;
      FSC_OP_ERS_SUSP:  cmd = `FSC_CMD_ERS_SUSP;
      FSC_OP_PRG_SUSP:  cmd = `FSC_CMD_PRG_SUSP;
      FSC_OP_ERS_RES:   cmd = `FSC_CMD_ERS_RES;
      FSC_OP_PRG_RES:   cmd = `FSC_CMD_PRG_RES;
      default:          cmd = `FSC_CMD_STATUS;
    endcase
    if (polling) begin
      cmd = `FSC_CMD_STATUS;
    end
    if (op == FSC_OP_ECC_ENTRY && !polling) begin
      // unlock pair, then entry at the page address
      if (step == 2'h0) begin
        return {1'b0, `FSC_UNLOCK_A1, `FSC_UNLOCK_D1};
      end else if (step == 2'h1) begin
        return {1'b0, `FSC_UNLOCK_A2, `FSC_UNLOCK_D2};
      end
      return {1'b1, addr, `FSC_CMD_ECC_ENTRY};
    end
    return {1'b1, `FSC_UNLOCK_A1, cmd};
  endfunction

  function automatic logic fsc_needs_read(input fsc_op_t op, input logic polling);
    return polling || op == FSC_OP_STATUS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    logic [`FSC_ADDR_W+`FSC_DATA_W:0] w;
    fsc_data_t masked;
    w              = fsc_write_step(r.op, r.polling, r.step, r.addr);
    masked         = cyc.rdata & `FSC_MASK_DEFINED;
    next_r         = r;
    next_r.req     = 1'b0;
    next_r.rsp     = 1'b0;
    case (r.st)
      FSC_S_IDLE: begin
        if (cmdValid) begin
          next_r.ready   = 1'b0;
          next_r.op      = fsc_op_t'(cmdOp);
          next_r.addr    = cmdAddr;
          next_r.step    = 2'h0;
          next_r.polling = 1'b0;
          next_r.polls   = 10'h000;
          next_r.issued  = 1'b0;
          next_r.refused = 1'b0;
          next_r.timeout = 1'b0;
          if (fsc_op_t'(cmdOp) == FSC_OP_HWRST) begin
            next_r.st  = FSC_S_HWRST;
            next_r.hwN = 1'b0;
            next_r.cnt = 16'(`FSC_HWRST_CYC - 1);
          end else if (fsc_op_t'(cmdOp) == FSC_OP_SOFTRST && !r.devReady) begin
            // a reset written mid-algorithm would be ignored anyway
            next_r.refused = 1'b1;
            next_r.st      = FSC_S_DONE;
          end else begin
            next_r.st = FSC_S_WRITE;
          end
        end
      end
      FSC_S_WRITE: begin
        if (!r.issued) begin
          next_r.req     = 1'b1;
          next_r.issued  = 1'b1;
          next_r.isWrite = 1'b1;
          next_r.cAddr   = w[`FSC_ADDR_W+`FSC_DATA_W-1:`FSC_DATA_W];
          next_r.cData   = w[`FSC_DATA_W-1:0];
        end else if (cyc.done) begin
          next_r.issued = 1'b0;
          if (!w[`FSC_ADDR_W+`FSC_DATA_W]) begin
            next_r.step = r.step + 2'h1;
          end else if (fsc_needs_read(r.op, r.polling)) begin
            // status write latched; the very next access must be the read
            next_r.st = FSC_S_READ;
          end else begin
            // soft reset, clear and resume need no extra wait; a suspend goes on to poll
            next_r.st = FSC_S_DONE;
            if (r.op == FSC_OP_SOFTRST) begin
              next_r.devReady = 1'b1;
            end
            if (r.op == FSC_OP_ERS_SUSP || r.op == FSC_OP_PRG_SUSP) begin
              next_r.st      = FSC_S_WRITE;
              next_r.polling = 1'b1;
            end
          end
        end
      end
      FSC_S_READ: begin
        if (!r.issued) begin
          next_r.req     = 1'b1;
          next_r.issued  = 1'b1;
          next_r.isWrite = 1'b0;
          next_r.cAddr   = r.addr;
        end else if (cyc.done) begin
          // this single read also closes the status overlay
          next_r.issued   = 1'b0;
          next_r.devReady = masked[`FSC_BIT_READY];
          next_r.status   = masked[`FSC_BIT_READY] ? masked : `FSC_MASK_READY & masked;
          next_r.st       = FSC_S_DONE;
          if (r.polling && !masked[`FSC_BIT_READY]) begin
            if (r.polls == 10'(`FSC_POLL_LIMIT)) begin
              // device stuck busy; only the hardware pin can recover it
              next_r.timeout = 1'b1;
              next_r.st      = FSC_S_HWRST;
              next_r.hwN     = 1'b0;
              next_r.cnt     = 16'(`FSC_HWRST_CYC - 1);
            end else begin
              next_r.polls = r.polls + 10'h001;
              next_r.st    = FSC_S_WRITE;
            end
          end
        end
      end
      FSC_S_HWRST: begin
        if (r.cnt != 16'h0000) begin
          next_r.cnt = r.cnt - 16'h0001;
        end else if (!r.hwN) begin
          next_r.hwN = 1'b1;
          next_r.cnt = 16'(RECOVER_CYC);
        end else begin
          next_r.devReady = 1'b1;
          next_r.status   = `FSC_MASK_READY;
          next_r.st       = FSC_S_DONE;
        end
      end
      FSC_S_DONE: begin
        next_r.rsp   = 1'b1;
        next_r.ready = 1'b1;
        next_r.st    = FSC_S_IDLE;
      end
      default: next_r.st = FSC_S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: FSC_S_IDLE, op: FSC_OP_STATUS, addr: '0, step: 2'h0,
             polling: 1'b0, polls: 10'h000, req: 1'b0, isWrite: 1'b0,
             cAddr: '0, cData: '0, issued: 1'b0, cnt: 16'h0000,
             devReady: 1'b1, ready: 1'b1, rsp: 1'b0, status: '0,
             refused: 1'b0, timeout: 1'b0, hwN: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign cyc.req     = r.req;
  assign cyc.isWrite = r.isWrite;
  assign cyc.addr    = r.cAddr;
  assign cyc.wdata   = r.cData;
  assign cmdReady    = r.ready;
  assign rspValid    = r.rsp;
  assign rspStatus   = r.status;
  assign rspRefused  = r.refused;
  assign rspTimeout  = r.timeout;
  assign hwResetN    = r.hwN;

  ////////////////////////////////////////////////////////////////////////////

  reserved_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rspValid |-> rspStatus[15:8] == 8'h00 && !rspStatus[0])
    else $error("reserved status bits not masked");
  busy_mask_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rspValid && !rspStatus[7] |-> rspStatus[6:1] == 6'h00)
    else $error("busy status carries result bits");
  suspend_ready_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rspValid && !rspTimeout && (r.op == FSC_OP_ERS_SUSP || r.op == FSC_OP_PRG_SUSP)
    |-> rspStatus[7])
    else $error("suspend answered before device ready");
  hw_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(hwResetN) |-> !hwResetN [*8])
    else $error("hardware reset pulse too short");
  read_follows_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    r.st == FSC_S_READ && r.req |-> !r.isWrite ##1 r.st == FSC_S_READ)
    else $error("status read not issued as a read");
  refuse_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmdValid && cmdReady && cmdOp == 4'h2 && !r.devReady |-> ##2 rspValid && rspRefused)
    else $error("soft reset not refused while busy");

endmodule // fsc_status_ctrl
`default_nettype wire

// File: sim/flash_status_reg_and_soft_reset_tb.sv
// self-checking bench for fsc_status_ctrl against a behavioural flash
// assumes fsc_flash_model on the flash pins and a 100 MHz sys_clk
`default_nettype none
module flash_status_reg_and_soft_reset_tb
  import fsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk  = 1'b0;
  logic       rstn     = 1'b0;
  logic       cmdValid = 1'b0;
  logic [3:0] cmdOp    = 4'h0;
  fsc_addr_t  cmdAddr  = 26'h0000000;
  logic       busy     = 1'b0;
  logic       loadEn   = 1'b0;
  fsc_data_t  loadWord = 16'h0000;
  logic       cmdReady, rspValid, rspRefused, rspTimeout, rRef, rTo;
  logic       chipEnN, outEnN, wrEnN, hwResetN, dqOeN, statusOvl, eccOvl;
  fsc_addr_t  flashAddr, rdAddr, wrAddr;
  fsc_data_t  rspStatus, dqOut, dqIn, rStat;
  int         mismatches = 0;
  int         checksDone = 0;
  int         ceFalls    = 0;
  int         hwPulses   = 0;

  always #5 sys_clk = ~sys_clk;
  always @(negedge chipEnN) ceFalls++;
  always @(negedge hwResetN) hwPulses++;
  // address seen by the flash as each strobe opens or closes
  always @(negedge outEnN) rdAddr = flashAddr;
  always @(posedge wrEnN) wrAddr = flashAddr;

  fsc_status_ctrl #(.RECOVER_CYC(5)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspStatus(rspStatus), .rspRefused(rspRefused), .rspTimeout(rspTimeout),
    .chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN), .hwResetN(hwResetN),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));

  fsc_flash_model i_flash (
    .chipEnN(chipEnN), .outEnN(outEnN), .wrEnN(wrEnN), .hwResetN(hwResetN),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn), .busy(busy),
    .loadEn(loadEn), .loadWord(loadWord), .statusOvl(statusOvl), .eccOvl(eccOvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic testDone();
    if (mismatches == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // entered and left at a rising edge; results kept in rStat, rRef, rTo
  task automatic issue(input logic [3:0] op, input fsc_addr_t addr);
    int n;
    n = 0;
    cmdOp <= op;
    cmdAddr <= addr;
    cmdValid <= 1'b1;
    do @(posedge sys_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 40000);
    chk(n < 40000, "no response");
    rStat = rspStatus;
    rRef = rspRefused;
    rTo = rspTimeout;
  endtask

  task automatic preload(input fsc_data_t w);
    loadWord <= w;
    loadEn <= 1'b1;
    @(posedge sys_clk);
    loadEn <= 1'b0;
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic tResetValues();
    issue(4'h8, 26'h0000000);
    chk(rStat === 16'h0080 && hwPulses == 1, "hw reset status");
    issue(4'h0, 26'h3FFFFFF);
    chk(rStat === 16'h0080, "status after reset");
  endtask

  task automatic tResultBits();
    preload(16'h00BB);
    issue(4'h0, 26'h1234567);
    chk(rStat === 16'h00BA && statusOvl === 1'b0, "result bits");
    chk(rdAddr === 26'h1234567, "status read address");
    issue(4'h2, 26'h0000000);
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h00BA, "soft reset with abort set");
    issue(4'h1, 26'h0000000);
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h0080, "clear status");
    preload(16'h00B3);
    issue(4'h2, 26'h0000000);
    chk(rRef === 1'b0, "soft reset taken");
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h0080, "soft reset cleared results");
  endtask

  task automatic tSuspend();
    issue(4'h3, 26'h0000000);
    chk(rStat === 16'h00C0 && rTo === 1'b0, "erase suspend");
    issue(4'h1, 26'h0000000);
    issue(4'h2, 26'h0000000);
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h00C0, "state bits kept");
    issue(4'h5, 26'h0000000);
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h0080, "erase resume");
    issue(4'h4, 26'h0000000);
    chk(rStat === 16'h0084, "program suspend");
    issue(4'h6, 26'h0000000);
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h0080, "program resume");
  endtask

  task automatic tRefuse();
    int n;
    busy <= 1'b1;
    issue(4'h0, 26'h0000000);
    chk(rStat === 16'h0000, "busy status masked");
    n = ceFalls;
    issue(4'h2, 26'h0000000);
    chk(rRef === 1'b1 && ceFalls == n, "soft reset while busy");
    busy <= 1'b0;
    issue(4'h8, 26'h0000000);
    issue(4'h2, 26'h0000000);
    chk(rRef === 1'b0, "soft reset after hw reset");
  endtask

  task automatic tEcc();
    issue(4'h7, 26'h0020000);
    chk(eccOvl === 1'b1 && statusOvl === 1'b0, "ecc overlay entry");
    chk(wrAddr === 26'h0020000, "ecc entry page address");
    issue(4'h0, 26'h0020000);
    chk(eccOvl === 1'b1 && rStat === 16'h0080, "status read in ecc map");
    issue(4'h2, 26'h0000000);
    chk(eccOvl === 1'b0, "soft reset leaves overlay");
  endtask

  task automatic tTimeout();
    int n;
    busy <= 1'b1;
    n = hwPulses;
    issue(4'h3, 26'h0000000);
    chk(rTo === 1'b1 && hwPulses == n + 1, "poll gave up");
    chk(rStat === 16'h0080, "status after hw reset");
    busy <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    tResetValues();
    tResultBits();
    tSuspend();
    tRefuse();
    tEcc();
    tTimeout();
    testDone();
  end

  // whole run is near 27k cycles; the long suspend poll dominates
  initial begin
    #700000;
    mismatches++;
    testDone();
  end
endmodule // flash_status_reg_and_soft_reset_tb
`default_nettype wire

// File: sim/fsc_flash_model.sv
// behavioural flash device: status word, status and ecc overlays, soft reset
// assumes the host pins of fsc_status_ctrl; busy holds the device busy
`default_nettype none
module fsc_flash_model
  import fsc_pkg::*;
(
  input  wire logic      chipEnN,
  input  wire logic      outEnN,
  input  wire logic      wrEnN,
  input  wire logic      hwResetN,
  input  wire fsc_addr_t flashAddr,
  input  wire fsc_data_t dqOut,
  input  wire logic      dqOeN,
  output wire fsc_data_t dqIn,
  input  wire logic      busy,
  input  wire logic      loadEn,
  input  wire fsc_data_t loadWord,
  output wire logic      statusOvl,
  output wire logic      eccOvl
);
  timeunit 1ns;
  timeprecision 1ns;
  fsc_data_t  stat     = 16'h0080;
  fsc_data_t  held     = 16'h0000;
  logic [7:0] junk     = 8'hA5;
  logic       inStat   = 1'b0;
  logic       inEcc    = 1'b0;
  int         suspWait = 0;
  logic       ready;

  assign ready = !busy && suspWait == 0;
  assign statusOvl = inStat;
  assign eccOvl = inEcc;
  // off the bus the lines show a moving pattern, never the last word
  assign dqIn = (!chipEnN && !outEnN) ?
      (inStat ? held : (inEcc ? 16'h0003 : flashAddr[15:0])) : {junk, ~junk};

  ////////////////////////////////////////////////////////////////////////////
  // dqOeN tells a write strobe edge from a read strobe edge
  always @(negedge hwResetN or posedge wrEnN or posedge outEnN or posedge loadEn) begin
    if (!hwResetN) begin
      stat = 16'h0080;
      inStat = 1'b0;
      inEcc = 1'b0;
      suspWait = 0;
    end else if (loadEn) begin
      stat = loadWord;
    end else if (!dqOeN) begin
      // no write ever clears inStat
      case (dqOut)
        16'h0070: begin
          held = ready ? {junk, 1'b1, stat[6:1], junk[0]}
                       : {junk, 1'b0, junk[5:0], junk[1]};
          inStat = 1'b1;
          if (suspWait > 0) suspWait--;
        end
        16'h0071: if (ready) stat = stat & 16'hFFC5;
        16'h00F0: begin
          if (ready) begin
            if (!stat[3]) stat = stat & 16'hFFCC;
            inEcc = 1'b0;
          end
        end
        16'h00B0: begin
          stat[6] = 1'b1;
          suspWait = 2;
        end
        16'h0051: begin
          stat[2] = 1'b1;
          suspWait = 2;
        end
        16'h0030: stat[6] = 1'b0;
        16'h0050: stat[2] = 1'b0;
        16'h0075: if (!inStat) inEcc = 1'b1;
        default: ;
      endcase
    end else begin
      junk = junk + 8'h3B;
      inStat = 1'b0;
    end
  end
endmodule // fsc_flash_model
`default_nettype wire
